// ==== kpc_i2c_slave.sv ====
// Notes on behaviour
// - Command then STOP only sets pointer.
// - First data byte goes to pointer.
// - Further write bytes use incremented pointer.
// - Read returns register at stored pointer.
// - Reads advance pointer by same rules.
// - Pointer advances only per burst byte.
// - Key config top bit resets scanning.
// - GPIO config bit four resets GPIO.
// - Increment: 0x06 wraps to FIFO, 0x01-0x05 and 0x40-0x5F step, else holds.
// - Address 0111 plus select pin code.
// - Long SCL low abandons transfer.
`default_nettype none
module kpc_i2c_slave #(
   parameter int TIMEOUT_CYCLES = kpc_pkg::TIMEOUT_CYCLES
) (
   input  wire logic       clock,
   input  wire logic       rst,
   input  wire logic       scl_in,
   input  wire logic       sda_in,
   output logic            sda_out,
   output logic            sda_oe,
   input  wire logic [1:0] bus_address_select_pin,
   input  wire logic       timeout_enable,
   output logic [7:0]      reg_addr,
   output logic [7:0]      reg_wdata,
   output logic            reg_write,
   output logic            reg_read,
   input  wire logic [7:0] reg_rdata,
   output logic            key_scan_soft_reset,
   output logic            gpio_soft_reset,
   output logic [7:0]      key_scan_configuration,
   output logic [7:0]      gpio_global_configuration
);
   ////////////////////////////////////////////////////////////////////////////
   // Synchronisers and edge detection.
   logic [1:0] scl_sync;
   logic [1:0] sda_sync;
   logic       scl_d;
   logic       sda_d;
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         scl_sync <= 2'h3;
         sda_sync <= 2'h3;
         scl_d    <= 1'b1;
         sda_d    <= 1'b1;
      end else begin
         scl_sync <= {scl_sync[0], scl_in};
         sda_sync <= {sda_sync[0], sda_in};
         scl_d    <= scl_sync[1];
         sda_d    <= sda_sync[1];
      end
   end
   wire scl      = scl_sync[1];
   wire sda      = sda_sync[1];
   wire scl_rise = scl & ~scl_d;
   wire scl_fall = ~scl & scl_d;
   wire start_c  = scl & scl_d & sda_d & ~sda;
   wire stop_c   = scl & scl_d & ~sda_d & sda;

   ////////////////////////////////////////////////////////////////////////////
   // Address match.
   logic [1:0] sel_meta;
   logic [1:0] sel_code;
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         sel_meta <= kpc_pkg::SEL_GND;
         sel_code <= kpc_pkg::SEL_GND;
      end else begin
         sel_meta <= bus_address_select_pin;
         sel_code <= sel_meta;
      end
   end
   logic [7:0] shift;
   wire addr_hit = (shift[7:4] == kpc_pkg::ADDR_HIGH) && (shift[3:2] == sel_code) && !shift[1];

   ////////////////////////////////////////////////////////////////////////////
   // Timeout counter on SCL low.
   logic [31:0] low_cnt;
   wire         timeout = timeout_enable && (low_cnt >= TIMEOUT_CYCLES);
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         low_cnt <= '0;
      end else if (scl) begin
         low_cnt <= '0;
      end else if (low_cnt < TIMEOUT_CYCLES) begin
         low_cnt <= low_cnt + 32'h1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Byte engine.
   kpc_pkg::kpc_state_t state;
   logic [3:0] bitn;
   logic       rw;
   logic       have_cmd;
   logic       nack;
   logic [7:0] ptr;
   logic [7:0] next_ptr;
   logic [7:0] txbyte;
   logic       bump;

   kpc_ptr_next u_next (
      .ptr      (ptr),
      .next_ptr (next_ptr)
   );

   assign reg_addr = ptr;

   wire byte_done  = scl_rise && (bitn == 4'h7);
   wire [7:0] rx_b = {shift[6:0], sda};
   wire wr_data    = (state == kpc_pkg::KPC_RX) && byte_done && have_cmd;
   wire wr_cmd     = (state == kpc_pkg::KPC_RX) && byte_done && !have_cmd;

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         state     <= kpc_pkg::KPC_IDLE;
         bitn      <= 4'h0;
         shift     <= 8'h00;
         rw        <= 1'b0;
         have_cmd  <= 1'b0;
         nack      <= 1'b0;
         ptr       <= kpc_pkg::PTR_RESET;
         txbyte    <= 8'h00;
         sda_out   <= 1'b1;
         sda_oe    <= 1'b0;
         reg_write <= 1'b0;
         reg_read  <= 1'b0;
         reg_wdata <= 8'h00;
         bump      <= 1'b0;
      end else begin
         reg_write <= 1'b0;
         reg_read  <= 1'b0;
         if (start_c) begin
            state    <= kpc_pkg::KPC_ADDR;
            bitn     <= 4'h0;
            have_cmd <= 1'b0;
            sda_oe   <= 1'b0;
         end else if (stop_c || timeout) begin
            state  <= kpc_pkg::KPC_IDLE;
            sda_oe <= 1'b0;
         end else begin
            unique case (state)
               kpc_pkg::KPC_IDLE: begin
                  sda_oe <= 1'b0;
               end
               kpc_pkg::KPC_ADDR: begin
                  if (scl_rise) begin
                     shift <= rx_b;
                     bitn  <= bitn + 4'h1;
                  end
                  if (scl_fall && bitn == 4'h8) begin
                     if (addr_hit) begin
                        rw     <= shift[0];
                        sda_oe <= 1'b1;
                        sda_out <= 1'b0;
                        state  <= kpc_pkg::KPC_ACK;
                     end else begin
                        state <= kpc_pkg::KPC_IDLE;
                     end
                  end
               end
               kpc_pkg::KPC_ACK: begin
                  if (scl_fall) begin
                     bitn <= 4'h0;
                     if (rw) begin
                        txbyte  <= reg_rdata;
                        sda_out <= reg_rdata[7];
                        sda_oe  <= ~reg_rdata[7];
                        reg_read <= 1'b1;
                        state   <= kpc_pkg::KPC_TX;
                     end else begin
                        sda_oe <= 1'b0;
                        state  <= kpc_pkg::KPC_RX;
                     end
                  end
               end
               kpc_pkg::KPC_RX: begin
                  if (scl_rise) begin
                     shift <= rx_b;
                     bitn  <= bitn + 4'h1;
                  end
                  if (wr_cmd) begin
                     ptr      <= rx_b;
                     have_cmd <= 1'b1;
                  end
                  if (wr_data) begin
                     reg_wdata <= rx_b;
                     reg_write <= 1'b1;
                     bump      <= 1'b1;
                  end
                  if (bump) begin
                     ptr  <= next_ptr;
                     bump <= 1'b0;
                  end
                  if (scl_fall && bitn == 4'h8) begin
                     sda_out <= 1'b0;
                     sda_oe  <= 1'b1;
                     state   <= kpc_pkg::KPC_ACK;
                  end
               end
               kpc_pkg::KPC_TX: begin
                  if (scl_fall) begin
                     bitn <= bitn + 4'h1;
                     if (bitn == 4'h7) begin
                        sda_oe <= 1'b0;
                        ptr    <= next_ptr;
                        state  <= kpc_pkg::KPC_RACK;
                     end else begin
                        sda_out <= txbyte[3'h6 - bitn[2:0]];
                        sda_oe  <= ~txbyte[3'h6 - bitn[2:0]];
                     end
                  end
               end
               kpc_pkg::KPC_RACK: begin
                  if (scl_rise) begin
                     nack <= sda;
                  end
                  if (scl_fall) begin
                     bitn <= 4'h0;
                     if (nack) begin
                        state <= kpc_pkg::KPC_IDLE;
                     end else begin
                        txbyte   <= reg_rdata;
                        sda_out  <= reg_rdata[7];
                        sda_oe   <= ~reg_rdata[7];
                        reg_read <= 1'b1;
                        state    <= kpc_pkg::KPC_TX;
                     end
                  end
               end
               default: state <= kpc_pkg::KPC_IDLE;
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Local configuration registers and soft resets.
   wire wr_key  = reg_write && (ptr == kpc_pkg::REG_KEY_CFG);
   wire wr_gpio = reg_write && (ptr == kpc_pkg::REG_GPIO_CFG);
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         key_scan_configuration    <= 8'h00;
         gpio_global_configuration <= 8'h00;
         key_scan_soft_reset       <= 1'b0;
         gpio_soft_reset           <= 1'b0;
      end else begin
         if (wr_key) begin
            key_scan_configuration <= reg_wdata;
         end
         if (wr_gpio) begin
            gpio_global_configuration <= reg_wdata;
         end
         key_scan_soft_reset <= wr_key && reg_wdata[kpc_pkg::KEY_SOFT_RST_BIT];
         gpio_soft_reset <= wr_gpio && reg_wdata[kpc_pkg::GPIO_SOFT_RST_BIT];
      end
   end
endmodule
`default_nettype wire

// ==== kpc_pkg.sv ====
`default_nettype none
package kpc_pkg;
   localparam logic [3:0] ADDR_HIGH        = 4'h7;
   localparam logic [7:0] REG_FIFO         = 8'h00;
   localparam logic [7:0] REG_KEY_CFG      = 8'h01;
   localparam logic [7:0] REG_KEY_LAST     = 8'h05;
   localparam logic [7:0] REG_AUTO_SHDN    = 8'h06;
   localparam logic [7:0] REG_GPIO_CFG     = 8'h40;
   localparam logic [7:0] REG_GPIO_LAST    = 8'h5F;
   localparam logic [7:0] PTR_RESET        = 8'h00;
   localparam int         KEY_SOFT_RST_BIT = 7;
   localparam int         GPIO_SOFT_RST_BIT = 4;
   localparam logic [1:0] SEL_GND          = 2'h0;
   localparam logic [1:0] SEL_VCC          = 2'h1;
   localparam logic [1:0] SEL_SDA          = 2'h2;
   localparam logic [1:0] SEL_SCL          = 2'h3;
   localparam int         CLK_HZ           = 10_000_000;
   localparam int         TIMEOUT_MS       = 20;
   localparam int         TIMEOUT_CYCLES   = CLK_HZ / 1000 * TIMEOUT_MS;
   typedef enum logic [2:0] {
      KPC_IDLE = 3'h0,
      KPC_ADDR = 3'h1,
      KPC_ACK  = 3'h2,
      KPC_RX   = 3'h3,
      KPC_TX   = 3'h4,
      KPC_RACK = 3'h5
   } kpc_state_t;
endpackage
`default_nettype wire

// ==== kpc_ptr_next.sv ====
`default_nettype none
module kpc_ptr_next (
   input  wire logic [7:0] ptr,
   output logic      [7:0] next_ptr
);
   ////////////////////////////////////////////////////////////////////////////
   wire in_key  = (ptr >= kpc_pkg::REG_KEY_CFG) && (ptr <= kpc_pkg::REG_KEY_LAST);
   wire in_gpio = (ptr >= kpc_pkg::REG_GPIO_CFG) && (ptr <= kpc_pkg::REG_GPIO_LAST);
   assign next_ptr = (ptr == kpc_pkg::REG_AUTO_SHDN) ? kpc_pkg::REG_FIFO :
                     (in_key || in_gpio)             ? ptr + 8'h01 : ptr;
endmodule
`default_nettype wire

// ==== kpc_i2c_slave_properties.sv ====
`default_nettype none
module kpc_i2c_slave_properties #(
   parameter int TIMEOUT_CYCLES = kpc_pkg::TIMEOUT_CYCLES
) (
   input wire logic       clock,
   input wire logic       rst,
   input wire logic       scl_in,
   input wire logic       sda_oe,
   input wire logic       timeout_enable,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic       reg_write,
   input wire logic       key_scan_soft_reset,
   input wire logic       gpio_soft_reset,
   input wire logic [7:0] key_scan_configuration,
   input wire logic [7:0] gpio_global_configuration
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);
   logic [31:0] low_cnt;
   logic [7:0]  wr_ptr;
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         low_cnt <= 32'h0000_0000;
         wr_ptr  <= 8'h00;
      end else begin
         low_cnt <= (scl_in || !timeout_enable) ? 32'h0000_0000 : low_cnt + 32'h0000_0001;
         wr_ptr  <= reg_write ? reg_addr : wr_ptr;
      end
   end
   function automatic logic [7:0] step(input logic [7:0] p);
      return (p == 8'h00 || p == 8'h06) ? 8'h00 : p + 8'h01;
   endfunction
   sequence key_cfg_wr; reg_write && reg_addr == kpc_pkg::REG_KEY_CFG; endsequence
   sequence gpio_cfg_wr; reg_write && reg_addr == kpc_pkg::REG_GPIO_CFG; endsequence
   chk_ptr_step: assert property (
      reg_write && (reg_addr < 8'h07 || reg_addr[7:5] == 3'h2) |-> ##[1:2] reg_addr == step(wr_ptr))
      else $error("pointer did not step after a written byte");
   chk_key_copy: assert property (key_cfg_wr |=> key_scan_configuration == $past(reg_wdata))
      else $error("key scan configuration not stored");
   chk_gpio_copy: assert property (gpio_cfg_wr |=> gpio_global_configuration == $past(reg_wdata))
      else $error("gpio configuration not stored");
   chk_key_reset: assert property (key_cfg_wr ##0 reg_wdata[7] |-> ##[0:2] key_scan_soft_reset)
      else $error("key scan reset not raised");
   chk_gpio_reset: assert property (gpio_cfg_wr ##0 reg_wdata[4] |-> ##[0:2] gpio_soft_reset)
      else $error("gpio reset not raised");
   chk_reset_pulse: assert property (key_scan_soft_reset |=> !key_scan_soft_reset)
      else $error("key scan reset longer than one cycle");
   chk_cfg_cause: assert property ($changed(key_scan_configuration) |-> reg_write || $past(reg_write))
      else $error("configuration changed without a write");
   chk_timeout_free: assert property (timeout_enable && low_cnt > TIMEOUT_CYCLES + 8 |-> !sda_oe)
      else $error("data line held after clock timeout");
endmodule
bind kpc_i2c_slave kpc_i2c_slave_properties #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) kpc_i2c_slave_properties_i (
   .clock(clock), .rst(rst), .scl_in(scl_in), .sda_oe(sda_oe), .timeout_enable(timeout_enable),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .key_scan_soft_reset(key_scan_soft_reset),
   .gpio_soft_reset(gpio_soft_reset), .key_scan_configuration(key_scan_configuration),
   .gpio_global_configuration(gpio_global_configuration));
`default_nettype wire

// ==== kpc_i2c_master.sv ====
`default_nettype none
module kpc_i2c_master (
   input  wire logic clock,
   input  wire logic sda,
   output logic      scl,
   output logic      sda_drv
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      scl = 1'b1;
      sda_drv = 1'b1;
   end
   task automatic q();
      repeat (2) @(negedge clock);
   endtask
   task automatic seq(input logic [3:0] v, output logic s);
      sda_drv = v[3];
      q();
      scl = v[2];
      q();
      s = sda;
      sda_drv = v[1];
      q();
      scl = v[0];
      q();
   endtask
   task automatic xfer(input logic [7:0] w, input logic mack, output logic [7:0] r, output logic sack);
      for (int i = 7; i >= 0; i--) seq({w[i], 1'b1, w[i], 1'b0}, r[i]);
      seq({mack, 1'b1, mack, 1'b0}, sack);
   endtask
endmodule
`default_nettype wire

// ==== kpc_i2c_slave_tb_top.sv ====
`default_nettype none
module kpc_i2c_slave_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int TO = 50;
   logic        clock = 1'b0;
   logic        rst, scl, sda_drv, sda_out, sda_oe, reg_write, key_rst, gpio_rst, te, ack, s, rd_pulse;
   logic [1:0]  sel;
   logic [7:0]  reg_addr, reg_wdata, key_cfg, gpio_cfg, rd_b, ptr;
   logic [7:0]  mem [256];
   logic [7:0]  exp_m [256];
   logic [31:0] seed;
   int          n_fail, n_compared, n_key, n_gpio, e_key, e_gpio, cyc, n_rd, e_rd;
   wire logic   sda = sda_drv & ~(sda_oe & ~sda_out);
   always #50 clock = ~clock;
   always @(posedge clock) begin
      if (reg_write) mem[reg_addr] <= reg_wdata;
      if (key_rst === 1'b1) n_key++;
      if (gpio_rst === 1'b1) n_gpio++;
      if (rd_pulse === 1'b1) n_rd++;
      cyc++;
      if (cyc == 40000) begin
         n_fail++;
         tally_and_finish();
      end
   end
   kpc_i2c_slave #(.TIMEOUT_CYCLES(TO)) kpc_i2c_slave_i (.clock(clock), .rst(rst), .scl_in(scl), .sda_in(sda),
      .sda_out(sda_out), .sda_oe(sda_oe), .bus_address_select_pin(sel), .timeout_enable(te), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(rd_pulse), .reg_rdata(mem[reg_addr]),
      .key_scan_soft_reset(key_rst), .gpio_soft_reset(gpio_rst), .key_scan_configuration(key_cfg),
      .gpio_global_configuration(gpio_cfg));
   kpc_i2c_master kpc_i2c_master_i (.clock(clock), .sda(sda), .scl(scl), .sda_drv(sda_drv));
   function automatic logic [31:0] lfsr(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction
   function automatic logic [7:0] inc(input logic [7:0] p);
      return (p == 8'h00 || p == 8'h06) ? 8'h00 : p + 8'h01;
   endfunction
   task automatic chk(input string what, input logic [7:0] e, input logic [7:0] g);
      n_compared++;
      if (g !== e) begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", what, e, g);
      end
   endtask
   task automatic tally_and_finish();
      if (n_fail == 0 && n_compared > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic addr(input logic rw);
      kpc_i2c_master_i.seq(4'b1100, s);
      kpc_i2c_master_i.xfer({kpc_pkg::ADDR_HIGH, sel, 1'b0, rw}, 1'b1, rd_b, ack);
      chk("addr_ack", 8'h00, {7'h00, ack});
   endtask
   task automatic cmd(input logic [7:0] c, input int n, input logic stp);
      addr(1'b0);
      kpc_i2c_master_i.xfer(c, 1'b1, rd_b, ack);
      chk("cmd_ack", 8'h00, {7'h00, ack});
      ptr = c;
      for (int i = 0; i < n; i++) begin
         seed = lfsr(seed);
         kpc_i2c_master_i.xfer(seed[7:0], 1'b1, rd_b, ack);
         exp_m[ptr] = seed[7:0];
         if (ptr == 8'h01 && seed[7]) e_key++;
         if (ptr == 8'h40 && seed[4]) e_gpio++;
         ptr = inc(ptr);
      end
      if (stp) kpc_i2c_master_i.seq(4'b0111, s);
   endtask
   task automatic rd(input int n);
      e_rd += n;
      addr(1'b1);
      for (int i = 0; i < n; i++) begin
         kpc_i2c_master_i.xfer(8'hFF, i == n - 1, rd_b, ack);
         chk("rdata", exp_m[ptr], rd_b);
         ptr = inc(ptr);
      end
      kpc_i2c_master_i.seq(4'b0111, s);
      chk("ptr_read", ptr, reg_addr);
   endtask
   initial begin
      logic [7:0] c;
      int         n;
      rst = 1'b1;
      te = 1'b1;
      sel = 2'h0;
      seed = 32'h0001_4B42;
      for (int i = 0; i < 256; i++) begin
         mem[i] = 8'h00;
         exp_m[i] = 8'h00;
      end
      repeat (5) @(negedge clock);
      rst = 1'b0;
      repeat (3) @(negedge clock);
      chk("ptr_reset", 8'h00, reg_addr);
      for (int k = 0; k < 4; k++) begin
         sel = 2'(k);
         kpc_i2c_master_i.seq(4'b1100, s);
         kpc_i2c_master_i.xfer({kpc_pkg::ADDR_HIGH, ~sel, 2'b00}, 1'b1, rd_b, ack);
         kpc_i2c_master_i.seq(4'b0111, s);
         chk("wrong_addr", 8'h01, {7'h00, ack});
         cmd(8'h05, 0, 1'b1);
         chk("ptr_cmd", ptr, reg_addr);
         chk("mem_kept", exp_m[8'h05], mem[8'h05]);
      end
      cmd(8'h04, 4, 1'b1);
      cmd(8'h04, 0, 1'b0);
      rd(5);
      rd(2);
      cmd(8'h01, 2, 1'b1);
      cmd(8'h40, 2, 1'b1);
      for (int k = 0; k < 8; k++) begin
         seed = lfsr(seed);
         c = seed[0] ? {4'h4, seed[4:1]} : 8'(seed[3:1] % 3'h7);
         n = int'(seed[9:8]);
         cmd(c, n, 1'b1);
         cmd(c, 0, 1'b1);
         rd(n + 1);
      end
      cmd(8'h20, 0, 1'b1);
      te = 1'b0;
      addr(1'b1);
      e_rd++;
      repeat (TO + 20) @(negedge clock);
      chk("hold_oe", {7'h00, ~exp_m[ptr][7]}, {7'h00, sda_oe});
      te = 1'b1;
      repeat (TO + 20) @(negedge clock);
      chk("timeout_oe", 8'h00, {7'h00, sda_oe});
      cmd(8'h03, 1, 1'b1);
      chk("ptr_after", ptr, reg_addr);
      chk("key_cfg", exp_m[8'h01], key_cfg);
      chk("gpio_cfg", exp_m[8'h40], gpio_cfg);
      chk("key_resets", 8'(e_key), 8'(n_key));
      chk("gpio_resets", 8'(e_gpio), 8'(n_gpio));
      chk("read_strobes", 8'(e_rd), 8'(n_rd));
      tally_and_finish();
   end
endmodule
`default_nettype wire
